// ==== clock_switch_pkg.sv ====
// Constants, types and carriers shared by the clock source switch.
package clock_switch_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CLOCK_SOURCE_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] LOW_FREQ_CONTROL_OFFSET = 8'h01;

  localparam int IDLE_ENABLE_POS = 7;
  localparam int FREQ_SELECT_LSB = 4;
  localparam int PRIMARY_READY_POS = 3;
  localparam int FAST_STABLE_POS = 2;
  localparam int CLOCK_SELECT_LSB = 0;
  localparam int LOW_FREQ_SOURCE_POS = 7;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CLOCK_SELECT_RESET = 2'h0;
  localparam logic [2:0] FREQ_SELECT_RESET = 3'h4;
  localparam logic [2:0] FREQ_CODE_LOW = 3'h0;
  localparam logic [2:0] FREQ_CODE_DIRECT = 3'h7;
  localparam logic [1:0] SELECT_SECONDARY = 2'h1;
  localparam logic IDLE_ENABLE_RESET = 1'b0;
  localparam logic LOW_FREQ_SOURCE_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Switch timing in source clock edges, postscaler width and tick input count
  // ----------------------------------------------------------------------
  localparam logic [1:0] OLD_SOURCE_EDGES = 2'h2;
  localparam logic [1:0] NEW_SOURCE_EDGES = 2'h3;
  localparam int POSTSCALER_WIDTH = 8;
  localparam int TICK_INPUTS = 5;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    src_primary,
    src_secondary,
    src_internal
  } source_type;

  typedef enum logic [1:0] {
    mode_run,
    mode_idle,
    mode_sleep
  } power_mode_type;

  typedef enum logic [1:0] {
    switch_steady,
    switch_old,
    switch_new
  } switch_state_type;

  typedef struct packed {
    logic primary;
    logic secondary;
    logic fast_internal;
    logic slow_rc;
  } osc_enable_type;

  typedef struct packed {
    logic system;
    logic core;
    logic peripheral;
    logic watchdog;
  } clock_enable_type;

endpackage : clock_switch_pkg

// ==== osc_partner_model.sv ====
// Behavioural oscillators and fast oscillator lock for the clock switch.
`timescale 1ns/100ps

module osc_partner_model
  import clock_switch_pkg::*;
#(
  parameter int P_HALF = 100,
  parameter int S_HALF = 180,
  parameter int F_HALF = 120,
  parameter int R_HALF = 220,
  parameter int LOCK_NS = 410
)
(
  // Oscillator enables
  input wire osc_enable_type osc_enable,
  // Oscillator waveforms
  output logic primary_osc_in,
  output logic secondary_osc_in,
  output logic fast_internal_osc_in,
  output logic slow_rc_osc_in,
  output logic fast_internal_locked
);
  // A stopped oscillator rests low; the offset keeps edges off clk_sys.
  initial begin
    {primary_osc_in, secondary_osc_in, fast_internal_osc_in} = 3'h0;
    slow_rc_osc_in = 1'b0;
    #7;
    fork
      forever #(P_HALF) primary_osc_in = osc_enable.primary & ~primary_osc_in;
      forever #(S_HALF) secondary_osc_in =
        osc_enable.secondary & ~secondary_osc_in;
      forever #(F_HALF) fast_internal_osc_in =
        osc_enable.fast_internal & ~fast_internal_osc_in;
      forever #(R_HALF) slow_rc_osc_in = osc_enable.slow_rc & ~slow_rc_osc_in;
    join
  end

  // Lock follows enable after a settling time and drops with it.
  initial begin
    fast_internal_locked = 1'b0;
    forever begin
      wait (osc_enable.fast_internal);
      #(LOCK_NS) fast_internal_locked = osc_enable.fast_internal;
      wait (!osc_enable.fast_internal);
      fast_internal_locked = 1'b0;
    end
  end
endmodule : osc_partner_model

// ==== oscillator_clock_switch_control.sv ====
// Clock source selection, glitch-free switching and power mode control.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps

module oscillator_clock_switch_control
  import clock_switch_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Oscillator waveforms, asynchronous to clk_sys
  input wire logic primary_osc_in,
  input wire logic secondary_osc_in,
  input wire logic fast_internal_osc_in,
  input wire logic slow_rc_osc_in,
  input wire logic fast_internal_locked,
  // Core, timer and configuration inputs on clk_sys
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic startup_timer_done,
  input wire logic secondary_osc_enable,
  input wire logic secondary_timer_needed,
  input wire logic sleep_rc_needed,
  input wire logic internal_external_switchover_cfg,
  input wire logic [3:0] primary_osc_mode_cfg,
  // Oscillator enables and clock enables
  output osc_enable_type osc_enable,
  output clock_enable_type clock_enable,
  // Status
  output logic secondary_running_flag,
  output logic [3:0] primary_mode,
  output power_mode_type power_mode
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic source_type decode_select(input logic [1:0] sel);
    decode_select = sel[1] ? src_internal :
      (sel[0] ? src_secondary : src_primary);
  endfunction : decode_select

  // Returns true when the postscaler count closes one divided period.
  function automatic logic post_hit(input logic [2:0] code,
    input logic [POSTSCALER_WIDTH-1:0] cnt);
    logic [POSTSCALER_WIDTH-1:0] mask;
    mask = (code == FREQ_CODE_LOW) ? '1 :
      POSTSCALER_WIDTH'((1 << (FREQ_CODE_DIRECT - code)) - 1);
    post_hit = ((cnt & mask) == mask);
  endfunction : post_hit

  // ----------------------------------------------------------------------
  // Synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [TICK_INPUTS-1:0] sync1_r;
  logic [TICK_INPUTS-1:0] sync2_r;
  logic [TICK_INPUTS-1:0] prev_r;
  logic primary_tick;
  logic secondary_tick;
  logic fast_tick;
  logic slow_tick;
  logic fast_locked;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= {fast_internal_locked, slow_rc_osc_in,
        fast_internal_osc_in, secondary_osc_in, primary_osc_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign primary_tick = sync2_r[0] & ~prev_r[0];
  assign secondary_tick = sync2_r[1] & ~prev_r[1];
  assign fast_tick = sync2_r[2] & ~prev_r[2];
  assign slow_tick = sync2_r[3] & ~prev_r[3];
  assign fast_locked = sync2_r[4];

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic idle_enable_r;
  logic [2:0] internal_freq_select_r;
  logic [1:0] system_clock_select_r;
  logic low_freq_source_select_r;
  logic ctrl_write;

  assign ctrl_write = reg_write && (reg_addr == CLOCK_SOURCE_CONTROL_OFFSET);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_enable_r <= IDLE_ENABLE_RESET;
      internal_freq_select_r <= FREQ_SELECT_RESET;
      system_clock_select_r <= CLOCK_SELECT_RESET;
    end else if (ctrl_write) begin
      idle_enable_r <= reg_wdata[IDLE_ENABLE_POS];
      internal_freq_select_r <= reg_wdata[FREQ_SELECT_LSB +: 3];
      if (reg_wdata[CLOCK_SELECT_LSB +: 2] != SELECT_SECONDARY ||
          secondary_osc_enable) begin
        system_clock_select_r <= reg_wdata[CLOCK_SELECT_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_freq_source_select_r <= LOW_FREQ_SOURCE_RESET;
    end else if (reg_write && reg_addr == LOW_FREQ_CONTROL_OFFSET) begin
      low_freq_source_select_r <= reg_wdata[LOW_FREQ_SOURCE_POS];
    end
  end

  // ----------------------------------------------------------------------
  // Power mode and two-speed start-up
  // ----------------------------------------------------------------------
  logic init_done_r;
  logic two_speed_r;
  power_mode_type mode_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= mode_run;
    end else if (sleep_exec && mode_r == mode_run) begin
      mode_r <= idle_enable_r ? mode_idle : mode_sleep;
    end else if (wake_event) begin
      mode_r <= mode_run;
    end
  end

  // The strap is caught on the first edge after reset release.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_done_r <= 1'b0;
      two_speed_r <= 1'b0;
    end else begin
      init_done_r <= 1'b1;
      if (!init_done_r) begin
        two_speed_r <= internal_external_switchover_cfg;
      end else if (wake_event && mode_r == mode_sleep) begin
        two_speed_r <= internal_external_switchover_cfg;
      end else if (startup_timer_done) begin
        two_speed_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Internal block frequency and postscaler
  // ----------------------------------------------------------------------
  logic [2:0] freq_eff;
  logic [POSTSCALER_WIDTH-1:0] post_cnt_r;
  logic slow_direct;
  logic internal_tick;

  assign freq_eff = two_speed_r ? FREQ_SELECT_RESET : internal_freq_select_r;
  assign slow_direct = (freq_eff == FREQ_CODE_LOW) &&
    !low_freq_source_select_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt_r <= '0;
    end else if (fast_tick) begin
      post_cnt_r <= post_cnt_r + POSTSCALER_WIDTH'(1);
    end
  end

  assign internal_tick = slow_direct ? slow_tick :
    (fast_tick && post_hit(freq_eff, post_cnt_r));

  // ----------------------------------------------------------------------
  // Glitch-free source switch
  // ----------------------------------------------------------------------
  source_type wanted_src;
  source_type active_src_r;
  source_type target_src_r;
  switch_state_type switch_r;
  logic [1:0] edge_cnt_r;
  logic active_tick;
  logic target_tick;

  function automatic logic tick_of(input source_type src,
    input logic p, input logic s, input logic i);
    case (src)
      src_primary: tick_of = p;
      src_secondary: tick_of = s;
      default: tick_of = i;
    endcase
  endfunction : tick_of

  assign wanted_src = (two_speed_r &&
    decode_select(system_clock_select_r) == src_primary) ?
    src_internal : decode_select(system_clock_select_r);

  assign active_tick = tick_of(active_src_r, primary_tick, secondary_tick,
    internal_tick);
  assign target_tick = tick_of(target_src_r, primary_tick, secondary_tick,
    internal_tick);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      switch_r <= switch_steady;
      active_src_r <= src_primary;
      target_src_r <= src_primary;
      edge_cnt_r <= 2'h0;
    end else begin
      case (switch_r)
        switch_steady: begin
          if (wanted_src != active_src_r) begin
            target_src_r <= wanted_src;
            edge_cnt_r <= 2'h0;
            switch_r <= switch_old;
          end
        end
        switch_old: begin
          if (active_tick) begin
            if (edge_cnt_r == OLD_SOURCE_EDGES - 2'h1) begin
              edge_cnt_r <= 2'h0;
              switch_r <= switch_new;
            end else begin
              edge_cnt_r <= edge_cnt_r + 2'h1;
            end
          end
        end
        switch_new: begin
          if (target_tick) begin
            if (edge_cnt_r == NEW_SOURCE_EDGES - 2'h1) begin
              active_src_r <= target_src_r;
              switch_r <= switch_steady;
            end else begin
              edge_cnt_r <= edge_cnt_r + 2'h1;
            end
          end
        end
        default: switch_r <= switch_steady;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Clock enables and oscillator enables
  // ----------------------------------------------------------------------
  logic sys_pulse;
  logic on_primary;
  logic want_primary;
  logic want_internal;
  logic fast_needed;

  assign sys_pulse = active_tick && switch_r == switch_steady &&
    mode_r != mode_sleep;
  assign on_primary = active_src_r == src_primary;
  assign want_primary = on_primary || target_src_r == src_primary ||
    wanted_src == src_primary;
  assign want_internal = active_src_r == src_internal ||
    target_src_r == src_internal || wanted_src == src_internal;
  assign fast_needed = (want_internal && !slow_direct) || two_speed_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_enable <= '0;
      osc_enable <= '0;
    end else begin
      clock_enable.system <= sys_pulse;
      clock_enable.core <= sys_pulse && mode_r == mode_run;
      clock_enable.peripheral <= sys_pulse;
      clock_enable.watchdog <= slow_tick;
      osc_enable.primary <= want_primary && mode_r != mode_sleep;
      osc_enable.secondary <= secondary_timer_needed ||
        (mode_r != mode_sleep && (active_src_r == src_secondary ||
        target_src_r == src_secondary));
      osc_enable.fast_internal <= fast_needed &&
        mode_r != mode_sleep;
      osc_enable.slow_rc <= sleep_rc_needed ||
        (want_internal && slow_direct && mode_r != mode_sleep);
    end
  end

  // ----------------------------------------------------------------------
  // Source status flags
  // ----------------------------------------------------------------------
  logic primary_ready_r;
  logic fast_stable_r;
  logic steady;

  assign steady = switch_r == switch_steady;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      primary_ready_r <= 1'b0;
      fast_stable_r <= 1'b0;
      secondary_running_flag <= 1'b0;
    end else if (!init_done_r) begin
      primary_ready_r <= !internal_external_switchover_cfg;
    end else begin
      primary_ready_r <= steady && on_primary &&
        startup_timer_done;
      fast_stable_r <= steady && active_src_r == src_internal &&
        !slow_direct && fast_locked;
      secondary_running_flag <= steady &&
        active_src_r == src_secondary;
    end
  end

  // ----------------------------------------------------------------------
  // Read port and plain status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        CLOCK_SOURCE_CONTROL_OFFSET: reg_rdata <= {idle_enable_r,
          internal_freq_select_r, primary_ready_r, fast_stable_r,
          system_clock_select_r};
        LOW_FREQ_CONTROL_OFFSET: reg_rdata <=
          {low_freq_source_select_r, 7'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      primary_mode <= 4'h0;
      power_mode <= mode_run;
    end else begin
      primary_mode <= primary_osc_mode_cfg;
      power_mode <= mode_r;
    end
  end

endmodule : oscillator_clock_switch_control

// ==== oscillator_clock_switch_control_assertions.sv ====
// Concurrent checks on the clock source switch ports.
`timescale 1ns/100ps

module oscillator_clock_switch_control_assertions
  import clock_switch_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Core and configuration
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic [3:0] primary_osc_mode_cfg,
  // Watched outputs
  input wire osc_enable_type osc_enable,
  input wire clock_enable_type clock_enable,
  input wire logic secondary_running_flag,
  input wire logic [3:0] primary_mode,
  input wire power_mode_type power_mode
);
  logic idle_r;
  logic ctl_rd;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  assign ctl_rd = reg_read && reg_addr == CLOCK_SOURCE_CONTROL_OFFSET;

  // Shadow of the idle enable bit as software last wrote it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= IDLE_ENABLE_RESET;
    end else if (reg_write && reg_addr == CLOCK_SOURCE_CONTROL_OFFSET) begin
      idle_r <= reg_wdata[IDLE_ENABLE_POS];
    end
  end

  AST_FLAGS_ONE: assert property (
    $past(ctl_rd) |-> $countones({reg_rdata[PRIMARY_READY_POS],
    reg_rdata[FAST_STABLE_POS], secondary_running_flag}) <= 1)
    else $error("two source flags set");
  AST_SLEEP_PICK: assert property (
    power_mode == mode_run && sleep_exec |-> ##[1:2]
    power_mode == (idle_r ? mode_idle : mode_sleep))
    else $error("wrong mode after sleep instruction");
  AST_MODE_CAUSE: assert property (
    $changed(power_mode) |-> $past(sleep_exec) || $past(wake_event)
    || $past(sleep_exec, 2) || $past(wake_event, 2))
    else $error("mode changed without cause");
  AST_WAKE_RUN: assert property (
    power_mode != mode_run && wake_event |-> ##[1:2] power_mode == mode_run)
    else $error("no return to run on wake");
  AST_SLEEP_OSC: assert property (
    power_mode == mode_sleep [*4] |->
    !osc_enable.primary && !osc_enable.fast_internal)
    else $error("oscillator left running in sleep");
  AST_SLEEP_CLK: assert property (
    power_mode == mode_sleep [*2] |-> !clock_enable.system
    && !clock_enable.core && !clock_enable.peripheral)
    else $error("clock pulse in sleep");
  AST_WDOG_RC: assert property (
    !osc_enable.slow_rc [*6] |-> !clock_enable.watchdog)
    else $error("watchdog pulse without slow oscillator");
  AST_STRAP: assert property (
    $stable(primary_osc_mode_cfg) [*3] |->
    primary_mode == primary_osc_mode_cfg)
    else $error("primary mode differs from strap");
  AST_IDLE_CORE: assert property (
    power_mode == mode_idle |-> !clock_enable.core)
    else $error("core clock pulse in idle");

  cover property (power_mode == mode_idle);
  cover property (power_mode == mode_sleep ##1 wake_event);
  cover property (secondary_running_flag);
  cover property (power_mode == mode_idle && clock_enable.peripheral);
endmodule : oscillator_clock_switch_control_assertions

bind oscillator_clock_switch_control
  oscillator_clock_switch_control_assertions u_assert (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .sleep_exec, .wake_event, .primary_osc_mode_cfg,
    .osc_enable, .clock_enable, .secondary_running_flag, .primary_mode,
    .power_mode
  );

// ==== oscillator_clock_switch_control_tb_top.sv ====
// Self-checking bench for the clock source switch.
`timescale 1ns/100ps

module oscillator_clock_switch_control_tb_top
  import clock_switch_pkg::*;
;
  localparam logic [7:0] CTL = CLOCK_SOURCE_CONTROL_OFFSET;
  localparam logic [7:0] LFC = LOW_FREQ_CONTROL_OFFSET;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sleep_exec = 1'b0;
  logic wake_event = 1'b0;
  logic startup_timer_done = 1'b1;
  logic secondary_osc_enable = 1'b0;
  logic secondary_timer_needed = 1'b0;
  logic sleep_rc_needed = 1'b1;
  logic switchover_cfg = 1'b0;
  logic [3:0] mode_cfg = 4'h5;
  logic [7:0] reg_rdata;
  logic primary_osc_in, secondary_osc_in, fast_internal_osc_in;
  logic slow_rc_osc_in, fast_internal_locked, secondary_running_flag;
  logic [3:0] primary_mode;
  osc_enable_type osc_enable;
  clock_enable_type clock_enable;
  power_mode_type power_mode;
  int fails = 0;
  int tests_run = 0;
  int gap = 0;
  int gap_max = 0;
  int n;

  always #20 clk_sys = ~clk_sys;

  oscillator_clock_switch_control u_dut (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .primary_osc_in, .secondary_osc_in, .fast_internal_osc_in,
    .slow_rc_osc_in, .fast_internal_locked, .sleep_exec, .wake_event,
    .startup_timer_done, .secondary_osc_enable, .secondary_timer_needed,
    .sleep_rc_needed, .internal_external_switchover_cfg(switchover_cfg),
    .primary_osc_mode_cfg(mode_cfg), .osc_enable, .clock_enable,
    .secondary_running_flag, .primary_mode, .power_mode
  );
  osc_partner_model u_osc (
    .osc_enable, .primary_osc_in, .secondary_osc_in, .fast_internal_osc_in,
    .slow_rc_osc_in, .fast_internal_locked
  );

  // Longest pause between system clock pulses.
  always @(negedge clk_sys) begin
    if (clock_enable.system === 1'b1) begin
      if (gap > gap_max) gap_max = gap;
      gap = 0;
    end else begin
      gap++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    chk({8'h00, reg_rdata & m}, {8'h00, e});
  endtask : rdc

  task automatic pulse(input logic w);
    @(posedge clk_sys);
    sleep_exec <= ~w;
    wake_event <= w;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    wake_event <= 1'b0;
    settle(6);
  endtask : pulse

  // Interval between the second and third pulse of the chosen enable.
  task automatic per(input logic wd, output int p);
    int c;
    int hits;
    c = 0;
    hits = 0;
    p = 0;
    for (int k = 0; k < 8000 && hits < 3; k++) begin
      @(negedge clk_sys);
      c++;
      if ((wd ? clock_enable.watchdog : clock_enable.system) === 1'b1) begin
        hits++;
        if (hits == 3) p = c;
        c = 0;
      end
    end
  endtask : per

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(10);
    rdc(CTL, 8'h48, 8'hff);
    rdc(LFC, 8'h00, 8'hff);
    chk({12'h0, primary_mode}, {12'h0, mode_cfg});
    wr(LFC, 8'h80);
    wr(8'h07, 8'hff);
    rdc(8'h07, 8'h00, 8'hff);
    rdc(LFC, 8'h80, 8'hff);
    wr(LFC, 8'h00);
    wr(CTL, 8'hc1);
    rdc(CTL, 8'hc8, 8'hff);
    wr(CTL, 8'h40);
    $display("done: registers");
    gap_max = 0;
    wr(CTL, 8'h72);
    settle(80);
    chk({15'h0, gap_max >= 18 && gap_max <= 55}, 16'h1);
    rdc(CTL, 8'h76, 8'hff);
    for (int c = 7; c >= 4; c--) begin
      wr(CTL, {1'b0, c[2:0], 4'h2});
      per(1'b0, n);
      chk(16'(n), 16'(6 << (7 - c)));
    end
    wr(LFC, 8'h80);
    wr(CTL, 8'h02);
    per(1'b0, n);
    chk(16'(n), 16'd1536);
    wr(LFC, 8'h00);
    per(1'b0, n);
    chk(16'(n), 16'd11);
    chk({15'h0, osc_enable.fast_internal}, 16'h0);
    rdc(CTL, 8'h02, 8'hff);
    $display("done: switching and frequency");
    wr(CTL, 8'hc2);
    pulse(1'b0);
    chk({14'h0, power_mode}, {14'h0, mode_idle});
    chk({15'h0, osc_enable.primary}, 16'h0);
    pulse(1'b1);
    chk({14'h0, power_mode}, {14'h0, mode_run});
    wr(CTL, 8'h42);
    secondary_timer_needed <= 1'b1;
    secondary_osc_enable <= 1'b1;
    pulse(1'b0);
    chk({14'h0, power_mode}, {14'h0, mode_sleep});
    chk({12'h0, osc_enable}, 16'h5);
    @(posedge clk_sys);
    sleep_rc_needed <= 1'b0;
    secondary_timer_needed <= 1'b0;
    settle(8);
    chk({12'h0, osc_enable}, 16'h0);
    @(posedge clk_sys);
    sleep_rc_needed <= 1'b1;
    secondary_timer_needed <= 1'b1;
    pulse(1'b1);
    $display("done: power modes");
    settle(50);
    wr(CTL, 8'h41);
    settle(200);
    chk({15'h0, secondary_running_flag}, 16'h1);
    rdc(CTL, 8'h41, 8'hff);
    per(1'b1, n);
    chk(16'(n), 16'd11);
    wr(CTL, 8'h80);
    settle(100);
    rdc(CTL, 8'h88, 8'hff);
    pulse(1'b0);
    chk({14'h0, power_mode}, {14'h0, mode_idle});
    chk({15'h0, osc_enable.primary}, 16'h1);
    pulse(1'b1);
    $display("done: secondary and primary idle");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    switchover_cfg <= 1'b1;
    startup_timer_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(20);
    rdc(CTL, 8'h40, 8'hfb);
    chk({15'h0, osc_enable.fast_internal}, 16'h1);
    @(posedge clk_sys);
    startup_timer_done <= 1'b1;
    settle(400);
    rdc(CTL, 8'h48, 8'hff);
    $display("done: two-speed start-up");
    results();
  end
endmodule : oscillator_clock_switch_control_tb_top
